// File: core/cst_pkg.sv
// Shared constants and carrier types for the clocked serial master transmitter
package cst_pkg;
  localparam int DIV_W = 8; // Width of bit rate divisor
  localparam int DATA_BITS = 8; // Plain character width
  localparam int CHAR_W = 9; // Character width with ninth bit
  localparam int WORD_W = 10; // Buffered word: {nine_bit_enable, ninth_bit_data, data}
  localparam int WORD_NINE_EN = 9; // Position of the nine-bit flag in a word
  localparam int FIFO_DEPTH = 16; // Buffer words ahead of the holding register
  localparam int CLOCK_PERIOD_NS = 5; // 200 MHz system clock
  localparam int BITCNT_W = 4; // Bits-left counter width
  localparam int HALF_W = 9; // Half-period counter width
  localparam logic [BITCNT_W-1:0] BITS_8 = 4'h8; // Bits per plain character
  localparam logic [BITCNT_W-1:0] BITS_9 = 4'h9; // Bits per nine-bit character
  localparam logic [BITCNT_W-1:0] BITS_LAST = 4'h1; // Last bit still on the line
  localparam logic [HALF_W-1:0] HALF_ZERO = 9'h000; // Counter start
  localparam logic [HALF_W-1:0] HALF_STEP = 9'h001; // Counter step

  // Configuration bits, held by software
  typedef struct packed {
    logic sync_mode; // Clocked mode select
    logic clock_source_master; // Master when set, slave when clear
    logic single_receive_enable; // Single receive request
    logic continuous_receive_enable; // Continuous receive request
    logic port_enable; // Whole port enable
    logic transmit_enable; // Transmitter enable
    logic nine_bit_enable; // Ninth bit per character
    logic ninth_bit_data; // Ninth bit value
    logic [DIV_W-1:0] bit_rate_divisor; // Divisor n: rate = fosc/(4(n+1))
  } cst_cfg_s;

  // Status bits reported back to software
  typedef struct packed {
    logic hold_empty; // Holding register free
    logic shift_empty; // Shift register fully drained
    logic data_pin_level; // Synchronised data pin level
  } cst_status_s;

  typedef enum logic {ST_IDLE, ST_SHIFT} cst_state_e;
endpackage

// File: core/cst_tx.sv
// Clocked serial master transmitter with its input buffer

// Buffer of words ahead of the holding register
module cst_fifo #(
  parameter int WIDTH = cst_pkg::WORD_W,
  parameter int DEPTH = cst_pkg::FIFO_DEPTH
) (
  input wire logic i_clock, // System clock
  input wire logic i_srst, // Synchronous reset
  input wire logic i_in_valid, // Word offered
  input wire logic [WIDTH-1:0] i_in_data, // Word in
  output logic o_in_ready, // Room for a word
  output logic o_out_valid, // Word available
  output logic [WIDTH-1:0] o_out_data, // Oldest word
  input wire logic i_out_ready // Drain side takes word
);
  localparam int AW = $clog2(DEPTH); // Pointer width
  localparam int CW = $clog2(DEPTH + 1); // Count width
  typedef struct packed {
    logic [AW-1:0] wr_ptr; // Next write slot
    logic [AW-1:0] rd_ptr; // Oldest slot
    logic [CW-1:0] count; // Words held
    logic in_ready; // Not full
    logic out_valid; // Not empty
  } cst_fifo_s;
  cst_fifo_s s_reg; // Pointer state
  cst_fifo_s s_next; // Next pointer state
  logic [WIDTH-1:0] mem [DEPTH]; // Word storage
  logic push; // Write accepted
  logic pop; // Read accepted

  // Flags are registered so both readies come from flops
  always_comb begin
    push = i_in_valid && s_reg.in_ready;
    pop = i_out_ready && s_reg.out_valid;
    s_next = s_reg;
    if (push) begin
      s_next.wr_ptr = AW'(s_reg.wr_ptr + 1'b1);
    end
    if (pop) begin
      s_next.rd_ptr = AW'(s_reg.rd_ptr + 1'b1);
    end
    s_next.count = CW'(s_reg.count + CW'(push) - CW'(pop));
    s_next.in_ready = s_next.count != CW'(DEPTH);
    s_next.out_valid = s_next.count != '0;
  end

  // Pointer register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s_reg <= '{wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Storage needs no reset; guarded by count
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[s_reg.wr_ptr] <= i_in_data;
    end
  end

  assign o_in_ready = s_reg.in_ready;
  assign o_out_valid = s_reg.out_valid;
  assign o_out_data = mem[s_reg.rd_ptr];
endmodule

// Transmitter core: holding register, hidden shift register, pins
module cst_tx (
  input wire logic i_clock, // System clock, 200 MHz
  input wire logic i_srst, // Synchronous reset, active high
  input wire cst_pkg::cst_cfg_s i_cfg, // Configuration bits
  input wire logic i_wr_valid, // Character write strobe
  input wire logic [cst_pkg::DATA_BITS-1:0] i_wr_data, // Character
  output logic o_wr_ready, // Buffer can take a character
  output cst_pkg::cst_status_s o_status, // Status bits
  input wire logic i_clock_pin_in, // Clock pin level
  output logic o_clock_pin_out, // Clock pin drive value
  output logic o_clock_pin_oe, // Clock pin driver enable
  input wire logic i_shared_data_in, // Data pin level
  output logic o_shared_data_out, // Data pin drive value
  output logic o_shared_data_oe // Data pin driver enable
);
  // Everything the core remembers; the shift register is internal only
  typedef struct packed {
    cst_pkg::cst_state_e state; // Idle or shifting
    logic [cst_pkg::CHAR_W-1:0] hold_data; // Holding register
    logic hold_full; // Holding register occupied
    logic hold_nine; // Holding character carries a ninth bit
    logic [cst_pkg::CHAR_W-1:0] shift_data; // Shift register
    logic [cst_pkg::BITCNT_W-1:0] bits_left; // Bits still to finish
    logic [cst_pkg::HALF_W-1:0] half_cnt; // Half-period counter
    logic first_rise; // Slave: first leading edge pending
    logic ck_meta; // Clock pin first stage
    logic ck_sync; // Clock pin second stage
    logic ck_prev; // Clock pin last value
    logic dt_meta; // Data pin first stage
    logic dt_sync; // Data pin second stage
    logic clk_out; // Clock pin value
    logic clk_oe; // Clock pin driver
    logic data_out; // Data pin value
    logic data_oe; // Data pin driver
  } cst_core_s;

  cst_core_s s_reg; // Core state
  cst_core_s s_next; // Next core state
  logic fifo_valid; // Buffered word present
  logic [cst_pkg::WORD_W-1:0] fifo_word; // Buffered word
  logic tx_mode; // Clocked transmit configured
  logic shift_done; // Last bit finishes this cycle
  logic load_go; // Holding moves into shift this cycle
  logic ck_rise; // External leading edge
  logic ck_fall; // External trailing edge
  logic [cst_pkg::HALF_W-1:0] half_last; // Terminal half count

  // Half period is 2(n+1) system clocks
  function automatic logic [cst_pkg::HALF_W-1:0] half_terminal(input logic [cst_pkg::DIV_W-1:0] n);
    half_terminal = {n, 1'b1};
  endfunction

  // Ninth bit is captured with the character so later changes cannot skew it
  cst_fifo #(.WIDTH(cst_pkg::WORD_W), .DEPTH(cst_pkg::FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_in_valid(i_wr_valid),
    .i_in_data({i_cfg.nine_bit_enable, i_cfg.ninth_bit_data, i_wr_data}),
    .o_in_ready(o_wr_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_word),
    .i_out_ready(!s_reg.hold_full)
  );

  // Core next-state logic
  always_comb begin
    s_next = s_reg;
    half_last = half_terminal(i_cfg.bit_rate_divisor);
    // Pin synchronisers; edge detection reads the second stage and its delayed copy ck_prev
    s_next.ck_meta = i_clock_pin_in;
    s_next.ck_sync = s_reg.ck_meta;
    s_next.ck_prev = s_reg.ck_sync;
    s_next.dt_meta = i_shared_data_in;
    s_next.dt_sync = s_reg.dt_meta;
    ck_rise = s_reg.ck_sync && !s_reg.ck_prev;
    ck_fall = !s_reg.ck_sync && s_reg.ck_prev;
    // Transmit only with receive off, port and transmitter on
    tx_mode = i_cfg.sync_mode && i_cfg.port_enable && !i_cfg.single_receive_enable
      && !i_cfg.continuous_receive_enable && i_cfg.transmit_enable;
    // Drivers follow configuration; never both directions on data
    s_next.clk_oe = i_cfg.sync_mode && i_cfg.port_enable && i_cfg.clock_source_master;
    s_next.data_oe = tx_mode;
    shift_done = 1'b0;
    // Holding register fills from the buffer when free
    if (!s_reg.hold_full && fifo_valid) begin
      s_next.hold_data = fifo_word[cst_pkg::CHAR_W-1:0];
      s_next.hold_full = 1'b1;
      // Length follows the setting at write time, not at load time
      s_next.hold_nine = fifo_word[cst_pkg::WORD_NINE_EN];
      if (!fifo_word[cst_pkg::WORD_NINE_EN]) begin
        s_next.hold_data[cst_pkg::CHAR_W-1] = 1'b0;
      end
    end
    if (s_reg.state == cst_pkg::ST_SHIFT) begin
      if (i_cfg.clock_source_master) begin
        // Master: own clock, data changes with each rise
        if (s_reg.half_cnt == half_last) begin
          s_next.half_cnt = cst_pkg::HALF_ZERO;
          if (s_reg.clk_out) begin
            s_next.clk_out = 1'b0;
          end else if (s_reg.bits_left == cst_pkg::BITS_LAST) begin
            // Count drops only at a new leading edge, so the last bit gets its own clock
            shift_done = 1'b1;
          end else begin
            // Next leading edge moves the next bit out, LSB first
            s_next.clk_out = 1'b1;
            s_next.bits_left = s_reg.bits_left - cst_pkg::BITS_LAST;
            s_next.shift_data = s_reg.shift_data >> 1;
            s_next.data_out = s_reg.shift_data[1];
          end
        end else begin
          s_next.half_cnt = s_reg.half_cnt + cst_pkg::HALF_STEP;
        end
      end else begin
        // Slave: shifts on the master's edges
        s_next.clk_out = 1'b0;
        if (ck_rise) begin
          s_next.first_rise = 1'b0;
          if (!s_reg.first_rise) begin
            s_next.shift_data = s_reg.shift_data >> 1;
            s_next.data_out = s_reg.shift_data[1];
          end
        end else if (ck_fall && !s_reg.first_rise) begin
          s_next.bits_left = s_reg.bits_left - cst_pkg::BITS_LAST;
          shift_done = s_reg.bits_left == cst_pkg::BITS_LAST;
        end
      end
      if (shift_done) begin
        s_next.state = cst_pkg::ST_IDLE;
      end
    end
    // Move holding into shift register at once when it is empty
    load_go = (s_reg.state == cst_pkg::ST_IDLE || shift_done) && s_reg.hold_full && tx_mode;
    if (load_go) begin
      s_next.state = cst_pkg::ST_SHIFT;
      s_next.shift_data = s_reg.hold_data;
      s_next.hold_full = 1'b0;
      s_next.bits_left = s_reg.hold_nine ? cst_pkg::BITS_9 : cst_pkg::BITS_8;
      s_next.data_out = s_reg.hold_data[0];
      s_next.clk_out = i_cfg.clock_source_master;
      s_next.half_cnt = cst_pkg::HALF_ZERO;
      s_next.first_rise = 1'b1;
    end
    // Port off or leaving clocked mode aborts the character
    if (!i_cfg.port_enable || !i_cfg.sync_mode) begin
      s_next.state = cst_pkg::ST_IDLE;
      s_next.clk_out = 1'b0;
      s_next.half_cnt = cst_pkg::HALF_ZERO;
    end
  end

  // Core register
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_clock_pin_out = s_reg.clk_out;
  assign o_clock_pin_oe = s_reg.clk_oe;
  assign o_shared_data_out = s_reg.data_out;
  assign o_shared_data_oe = s_reg.data_oe;
  // Hold free and shift drained, straight from flops
  assign o_status = '{hold_empty: !s_reg.hold_full, shift_empty: s_reg.state == cst_pkg::ST_IDLE,
                      data_pin_level: s_reg.dt_sync};

  // Helper counters for timing checks
  logic [cst_pkg::HALF_W:0] high_len; // Cycles clock has been high
  logic [cst_pkg::BITCNT_W:0] rise_cnt; // Leading edges this character
  logic nine_seen; // Character on the line carries nine bits
  always_ff @(posedge i_clock) begin
    high_len <= o_clock_pin_out ? high_len + 1'b1 : '0;
    if (load_go) begin
      // In master mode the load itself raises the first leading edge
      rise_cnt <= {{cst_pkg::BITCNT_W{1'b0}}, 1'b1};
      nine_seen <= s_reg.hold_nine;
    end else if (s_reg.state == cst_pkg::ST_IDLE) begin
      rise_cnt <= '0;
    end else if (s_next.clk_out && !s_reg.clk_out) begin
      rise_cnt <= rise_cnt + 1'b1;
    end
  end

  sequence s_load;
    s_reg.hold_full && tx_mode && s_reg.state == cst_pkg::ST_IDLE;
  endsequence
  sequence s_started;
    s_reg.state == cst_pkg::ST_SHIFT && !s_reg.hold_full;
  endsequence

  property p_clock_driver;
    @(posedge i_clock) disable iff (i_srst)
      i_cfg.sync_mode && i_cfg.port_enable && i_cfg.clock_source_master |=> o_clock_pin_oe;
  endproperty
  a_clock_driver: assert property (p_clock_driver) else $error("clock driver not enabled");
  property p_data_driver;
    @(posedge i_clock) disable iff (i_srst) tx_mode |=> o_shared_data_oe;
  endproperty
  a_data_driver: assert property (p_data_driver) else $error("data driver not enabled");
  property p_receive_off;
    @(posedge i_clock) disable iff (i_srst)
      i_cfg.single_receive_enable || i_cfg.continuous_receive_enable |=> !o_shared_data_oe;
  endproperty
  a_receive_off: assert property (p_receive_off) else $error("data driven while receiving");
  property p_port_off;
    @(posedge i_clock) disable iff (i_srst)
      !i_cfg.port_enable |=> !o_clock_pin_oe && !o_shared_data_oe && !o_clock_pin_out;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port active while disabled");
  property p_load_now;
    @(posedge i_clock) disable iff (i_srst) s_load |=> s_started ##0 o_shared_data_out == $past(s_reg.hold_data[0]);
  endproperty
  a_load_now: assert property (p_load_now) else $error("holding not loaded at once");
  property p_hold_waits;
    @(posedge i_clock) disable iff (i_srst) s_reg.hold_full && !shift_done && s_reg.state == cst_pkg::ST_SHIFT
      && i_cfg.port_enable |=> s_reg.hold_full;
  endproperty
  a_hold_waits: assert property (p_hold_waits) else $error("holding overwrote busy shift");
  property p_data_at_rise;
    @(posedge i_clock) disable iff (i_srst) i_cfg.clock_source_master && $past(i_cfg.clock_source_master)
      && $changed(o_shared_data_out) |-> $rose(o_clock_pin_out);
  endproperty
  a_data_at_rise: assert property (p_data_at_rise) else $error("data changed off leading edge");
  property p_half_period;
    @(posedge i_clock) disable iff (i_srst) $fell(o_clock_pin_out) && i_cfg.port_enable && $stable(i_cfg)
      |-> high_len == {1'b0, half_last} + 1'b1;
  endproperty
  a_half_period: assert property (p_half_period) else $error("bit clock half period wrong");
  property p_edge_count;
    @(posedge i_clock) disable iff (i_srst) shift_done && i_cfg.clock_source_master && i_cfg.port_enable
      |-> rise_cnt == {1'b0, (nine_seen ? cst_pkg::BITS_9 : cst_pkg::BITS_8)};
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("extra clock cycles");
  property p_idle_low;
    @(posedge i_clock) disable iff (i_srst) o_status.shift_empty |-> !o_clock_pin_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock not idle low");
endmodule

// File: sim/cst_slave_model.sv
// Listening slave on the shared clock and data lines, with bit capture and timing stats
module cst_slave_model (
  input wire logic i_clock, // System clock used to watch the lines
  input wire logic i_clear, // Clear captured bits and stats
  input wire logic i_clk_wire, // Clock line level
  input wire logic i_data_wire // Data line level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rx_bits [0:255]; // Captured bits in arrival order
  int bit_count = 0; // Bits captured since clear
  int run = 0; // Cycles the current clock level has held
  int min_hi; // Shortest high phase
  int max_hi; // Longest high phase
  int min_lo; // Shortest low phase inside traffic
  int max_lo; // Longest low phase inside traffic
  int unstable; // Data changes away from a leading edge
  logic clk_q = 1'b0; // Clock line one cycle ago
  logic data_q = 1'b0; // Data line one cycle ago
  logic lead; // Rising clock seen this cycle
  logic trail; // Falling clock seen this cycle
  assign lead = (i_clk_wire === 1'b1) && (clk_q === 1'b0);
  assign trail = (i_clk_wire === 1'b0) && (clk_q === 1'b1);

  // Slave only listens here; it never drives either line in master transmit
  always @(posedge i_clock) begin
    clk_q <= i_clk_wire;
    data_q <= i_data_wire;
    run <= (i_clk_wire !== clk_q) ? 1 : run + 1;
    if (i_clear) begin
      bit_count <= 0;
      min_hi <= 99999;
      max_hi <= 0;
      min_lo <= 99999;
      max_lo <= 0;
      unstable <= 0;
    end else begin
      // Low phase counted only between bits, not the idle before traffic
      if (lead && bit_count > 0) begin
        min_lo <= (run < min_lo) ? run : min_lo;
        max_lo <= (run > max_lo) ? run : max_lo;
      end
      // Sample on the trailing edge, as a real receiver does
      if (trail) begin
        rx_bits[bit_count[7:0]] <= i_data_wire;
        bit_count <= bit_count + 1;
        min_hi <= (run < min_hi) ? run : min_hi;
        max_hi <= (run > max_hi) ? run : max_hi;
      end
      // Data may only move together with a leading edge
      // Idle line before the first clock since the last clear is not judged
      if (i_data_wire !== data_q && !lead && (bit_count > 0 || i_clk_wire === 1'b1)) begin
        unstable <= unstable + 1;
      end
    end
  end
endmodule

// File: sim/cst_tx_tb.sv
// Self-checking bench for the clocked serial master transmitter
module cst_tx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0; // System clock
  logic i_srst = 1'b1; // Synchronous reset
  cst_pkg::cst_cfg_s i_cfg = '0; // Configuration bits
  logic i_wr_valid = 1'b0; // Write strobe
  logic [7:0] i_wr_data = 8'h00; // Write character
  logic o_wr_ready; // Buffer room
  cst_pkg::cst_status_s o_status; // Status bits
  logic o_clock_pin_out; // Clock drive value
  logic o_clock_pin_oe; // Clock driver enable
  logic o_shared_data_out; // Data drive value
  logic o_shared_data_oe; // Data driver enable
  logic clk_wire; // Resolved clock line
  logic data_wire; // Resolved data line
  logic clk_last = 1'b0; // Clock line last cycle
  logic data_last = 1'b0; // Data line last cycle
  logic clear = 1'b1; // Model stats clear
  logic ext_clk = 1'b0; // Far-side clock in slave role
  logic ext_clk_oe = 1'b0; // Far side drives the clock
  int errors = 0; // Mismatch count
  int checks_done = 0; // Comparison count

  // Undriven lines show the inverse of their last value, so stale data never passes
  assign clk_wire = o_clock_pin_oe ? o_clock_pin_out : ext_clk_oe ? ext_clk : ~clk_last;
  assign data_wire = o_shared_data_oe ? o_shared_data_out : ~data_last;
  // Unknown start-up levels must not lock the released lines at unknown
  always @(posedge i_clock) begin
    clk_last <= (clk_wire === 1'b1);
    data_last <= (data_wire === 1'b1);
  end

  // 200 MHz clock
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  cst_tx i_cst_tx (.i_clock(i_clock), .i_srst(i_srst), .i_cfg(i_cfg), .i_wr_valid(i_wr_valid),
    .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready), .o_status(o_status), .i_clock_pin_in(clk_wire),
    .o_clock_pin_out(o_clock_pin_out), .o_clock_pin_oe(o_clock_pin_oe), .i_shared_data_in(data_wire),
    .o_shared_data_out(o_shared_data_out), .o_shared_data_oe(o_shared_data_oe));
  cst_slave_model i_cst_slave_model (.i_clock(i_clock), .i_clear(clear), .i_clk_wire(clk_wire),
    .i_data_wire(data_wire));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Flags order: sync, master, single rx, cont rx, port, tx enable, nine, ninth
  task automatic cfg_set(input logic [7:0] flags, input logic [7:0] n);
    i_cfg <= {flags, n};
    repeat (3) @(posedge i_clock);
  endtask

  // Pulse the model clear while the line is quiet
  task automatic clr;
    clear <= 1'b1;
    @(posedge i_clock);
    clear <= 1'b0;
  endtask

  // Offer one character and hold it until taken; strobe left high for back-to-back use
  task automatic wr(input logic [7:0] d);
    int k;
    k = 0;
    i_wr_valid <= 1'b1;
    i_wr_data <= d;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_wr_ready !== 1'b1 && k < 2000);
  endtask

  // Drop the strobe and wait, bounded, until both holding and shift are empty
  task automatic wait_idle;
    int k;
    k = 0;
    i_wr_valid <= 1'b0;
    repeat (4) @(posedge i_clock);
    while (!(o_status.hold_empty === 1'b1 && o_status.shift_empty === 1'b1) && k < 20000) begin
      @(posedge i_clock);
      k++;
    end
    check(k < 20000, 1'b1);
  endtask

  // Rebuild a character from captured bits, first bit into bit 0
  function automatic logic [8:0] got(input int base, input int nb);
    logic [8:0] v;
    v = '0;
    for (int i = 0; i < nb; i++) begin
      v[i] = i_cst_slave_model.rx_bits[base + i];
    end
    return v;
  endfunction

  // Values straight out of reset
  task automatic t_reset;
    check(o_wr_ready, 1'b1);
    check({o_status.hold_empty, o_status.shift_empty}, 2'h3);
    check(o_clock_pin_out, 1'b0);
    $display("test reset done");
  endtask

  // Driver enables for six mode combinations
  task automatic t_enables;
    logic [7:0] fl [6];
    logic [1:0] ex [6];
    fl = '{8'hCC, 8'hC4, 8'hEC, 8'hDC, 8'h8C, 8'h4C};
    ex = '{2'h3, 2'h0, 2'h2, 2'h2, 2'h1, 2'h0};
    for (int i = 0; i < 6; i++) begin
      cfg_set(fl[i], 8'h00);
      check({o_clock_pin_oe, o_shared_data_oe}, ex[i]);
    end
    $display("test enables done");
  endtask

  // One character at a given divisor, plain or nine-bit
  task automatic t_char(input logic [7:0] flags, input logic [7:0] n, input logic [7:0] d);
    int nb;
    nb = flags[1] ? 9 : 8;
    cfg_set(flags, n);
    clr();
    wr(d);
    wait_idle();
    check(i_cst_slave_model.bit_count, nb);
    check(got(0, nb), {flags[1] & flags[0], d});
    check(i_cst_slave_model.min_hi, 2 * (n + 1));
    check(i_cst_slave_model.max_hi, 2 * (n + 1));
    check(i_cst_slave_model.max_lo, 2 * (n + 1));
    check(i_cst_slave_model.unstable, 0);
    check(o_clock_pin_out, 1'b0);
    check(o_status.data_pin_level, data_wire);
    $display("test char done");
  endtask

  // Slave role: far side drives the clock, data still leaves LSB first
  task automatic t_slave;
    cfg_set(8'h8C, 8'h00);
    ext_clk_oe <= 1'b1;
    clr();
    wr(8'h96);
    i_wr_valid <= 1'b0;
    repeat (8) @(posedge i_clock);
    for (int i = 0; i < 8; i++) begin
      ext_clk <= 1'b1;
      repeat (8) @(posedge i_clock);
      ext_clk <= 1'b0;
      repeat (8) @(posedge i_clock);
    end
    wait_idle();
    check(i_cst_slave_model.bit_count, 8);
    check(got(0, 8), 9'h096);
    check(o_clock_pin_oe, 1'b0);
    ext_clk_oe <= 1'b0;
    $display("test slave done");
  endtask

  // Three characters written back to back leave no idle gap
  task automatic t_b2b;
    logic [7:0] c [3];
    c = '{8'h81, 8'h7E, 8'h00};
    cfg_set(8'hCC, 8'h01);
    clr();
    for (int i = 0; i < 3; i++) begin
      wr(c[i]);
    end
    wait_idle();
    check(i_cst_slave_model.bit_count, 24);
    for (int i = 0; i < 3; i++) begin
      check(got(8 * i, 8), {1'b0, c[i]});
    end
    check(i_cst_slave_model.min_lo, 4);
    check(i_cst_slave_model.max_lo, 4);
    $display("test back_to_back done");
  endtask

  // Fill buffer with transmit off until refused, then drain in order
  task automatic t_fill;
    int acc;
    acc = 0;
    cfg_set(8'hC8, 8'h00);
    i_wr_valid <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      i_wr_data <= 8'h10 + acc[7:0];
      @(posedge i_clock);
      if (o_wr_ready === 1'b1) begin
        acc++;
      end
    end
    i_wr_valid <= 1'b0;
    @(posedge i_clock);
    check(acc, cst_pkg::FIFO_DEPTH + 1);
    check(o_wr_ready, 1'b0);
    check({o_status.hold_empty, o_status.shift_empty}, 2'h1);
    clr();
    cfg_set(8'hCC, 8'h00);
    wait_idle();
    check(i_cst_slave_model.bit_count, 8 * (cst_pkg::FIFO_DEPTH + 1));
    for (int i = 0; i <= cst_pkg::FIFO_DEPTH; i++) begin
      check(got(8 * i, 8), 9'h010 + i);
    end
    check(i_cst_slave_model.unstable, 0);
    $display("test fill_drain done");
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_enables();
    t_char(8'hCC, 8'h00, 8'hA5);
    t_char(8'hCF, 8'h03, 8'h3C);
    t_char(8'hCE, 8'hFF, 8'hC3);
    t_b2b();
    t_fill();
    t_slave();
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge i_clock);
    errors++;
    print_verdict();
  end
endmodule
